// ---- src/access_mode_bus_expansion.sv ----
/*
 Access-mode controller for the expansion connector of a microcontroller
 development system: access code, bus and port-2 drive ownership, monitor
 entry, timer interrupt gating, reset and bootstrap sequencing.
 Assumes all inputs synchronous to core_clk; the connector wire resolution is outside.
*/
// Operation
// [RULE_01] System calls reachable only in codes 2, 5.
// [RULE_02] User program memory lies above 1k.
// [RULE_03] User data memory above 1k; box data 0-FF.
// [RULE_04] Port-2 low nibble selects data page.
// [RULE_05] Connector omits external-access select, step, crystals.
// [RULE_06] Box drivers never fight user drivers.
// [RULE_07] Monitor interrupt pushes one stack entry.
// [RULE_08] Bus AND/OR only code 3, no-break run.
// [RULE_09] Latch-to-bus only in codes 0, 3.
// [RULE_10] Program 3F0-3FF reserved for reentry code.
// [RULE_11] PROM programming writes reentry code automatically.
// [RULE_12] Timer interrupt off under break, step runs.
// [RULE_13] Reset boots monitor from 4k store.
// [RULE_14] Reset line bidirectional; reset key overrides.
// [RULE_15] Reset key sets access 0, enters monitor.
// [RULE_16] Six access codes assign program memory.
// [RULE_17] Data above 3FF paged by port-2 nibble. The code pages it only in codes 1, 2, 4 and 5.
`default_nettype none
module access_mode_bus_expansion (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        systemResetKey,
   input  wire logic        monitorInterruptKey,
   input  wire logic        setAccess,
   input  wire logic [2:0]  accessIn,
   input  wire logic        portTwoMapSetting,
   input  wire logic        runStart,
   input  wire logic [1:0]  runCommand,
   input  wire logic        programPromCmd,
   input  wire logic        programDone,
   input  wire logic [11:0] progAddr,
   input  wire logic [11:0] dataAddr,
   input  wire logic        andToBusInstruction,
   input  wire logic        orToBusInstruction,
   input  wire logic        latchToBusInstruction,
   input  wire logic        timerIrqReq,
   input  wire logic [3:0]  portTwoLowIn,
   input  wire logic [3:0]  portTwoLowCpu,
   input  wire logic [7:0]  busCpuOut,
   input  wire logic        busCpuDrive,
   input  wire logic        resetLineIn,
   output logic [2:0]       accessCode,
   output logic             monitorActive,
   output logic             userRunning,
   output logic             bootActive,
   output logic             stackPush,
   output logic             reentryWrite,
   output logic [3:0]       reentryIndex,
   output logic             timerIrqOut,
   output logic             busOpAllowed,
   output logic             busOpFault,
   output logic [3:0]       dataPage,
   output logic             dataPageValid,
   output logic             progLowChip,
   output logic             progLowRam,
   output logic             progMonitor,
   output logic             progExternal,
   output logic             reentryHit,
   output logic             sysCallOk,
   output logic             dataInBox,
   output logic [7:0]       busOut,
   output logic             busOe,
   output logic [3:0]       portTwoLowOut,
   output logic             portTwoLowOe,
   output logic             resetLineOut,
   output logic             resetLineOe,
   output logic             cpuResetActive
);
   access_mode_pkg::mode_e  mode;
   logic [1:0]              runKind;
   logic [11:0]             bootCount;
   logic [3:0]              reentryCount;
   logic                    keyDelay;
   logic                    dataPaged;
   logic                    busIsPort;

   region_decode decoder (
      .accessCode   (accessCode),
      .monitorMode  (monitorActive),
      .progAddr     (progAddr),
      .dataAddr     (dataAddr),
      .progLowChip  (progLowChip),
      .progLowRam   (progLowRam),
      .progMonitor  (progMonitor),
      .progExternal (progExternal),
      .sysCallOk    (sysCallOk),
      .dataInBox    (dataInBox),
      .dataPaged    (dataPaged)
   );

   // Access code register: reset key forces code 0; codes above 5 are ignored.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         accessCode <= access_mode_pkg::ACCESS_RESET;
      end else if (systemResetKey) begin
         accessCode <= access_mode_pkg::ACCESS_RESET; // see [RULE_15]
      end else if (setAccess && monitorActive && accessIn <= access_mode_pkg::ACCESS_5) begin
         accessCode <= accessIn; // see [RULE_16]
      end
   end

   // Mode sequencer: boot, monitor, user run, and PROM programming.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode <= access_mode_pkg::ST_BOOT;
      end else if (systemResetKey) begin
         mode <= access_mode_pkg::ST_BOOT; // see [RULE_13]
      end else begin
         case (mode)
            access_mode_pkg::ST_BOOT: begin
               if (bootCount == 12'(access_mode_pkg::BOOT_CYCLES - 1)) begin
                  mode <= access_mode_pkg::ST_MONITOR; // see [RULE_15]
               end
            end
            access_mode_pkg::ST_MONITOR: begin
               if (programPromCmd) begin
                  mode <= access_mode_pkg::ST_PROGRAM;
               end else if (runStart) begin
                  mode <= access_mode_pkg::ST_USER;
               end
            end
            access_mode_pkg::ST_USER: begin
               if (monitorInterruptKey) begin
                  mode <= access_mode_pkg::ST_MONITOR; // see [RULE_07]
               end
            end
            access_mode_pkg::ST_PROGRAM: begin
               if (programDone && reentryCount == 4'hf) begin
                  mode <= access_mode_pkg::ST_MONITOR;
               end
            end
            default: begin
               mode <= access_mode_pkg::ST_BOOT;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bootCount <= 12'h000;
      end else if (systemResetKey || mode != access_mode_pkg::ST_BOOT) begin
         bootCount <= 12'h000;
      end else begin
         bootCount <= bootCount + 12'h001;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         runKind <= access_mode_pkg::RUN_NOBREAK;
      end else if (mode == access_mode_pkg::ST_MONITOR && runStart && !programPromCmd) begin
         runKind <= runCommand;
      end
   end

   // Reentry code is written over the 16 reserved top bytes of the low block.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reentryCount <= 4'h0;
      end else if (mode != access_mode_pkg::ST_PROGRAM) begin
         reentryCount <= 4'h0;
      end else if (programDone && reentryCount != 4'hf) begin
         reentryCount <= reentryCount + 4'h1; // see [RULE_11]
      end
   end

   // One push per key press: edge of the key while the user program runs.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         keyDelay <= 1'b0;
      end else begin
         keyDelay <= monitorInterruptKey;
      end
   end

   // Page latched from the port-2 low nibble for paged data accesses.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dataPage      <= 4'h0;
         dataPageValid <= 1'b0;
      end else begin
         dataPage      <= portTwoMapSetting ? portTwoLowIn : portTwoLowCpu; // see [RULE_04]
         dataPageValid <= dataPaged && !dataInBox; // see [RULE_17]
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busOut        <= 8'h00;
         portTwoLowOut <= 4'h0;
      end else begin
         busOut        <= busCpuOut;
         portTwoLowOut <= portTwoLowCpu;
      end
   end

   always_comb begin
      monitorActive  = mode == access_mode_pkg::ST_MONITOR || mode == access_mode_pkg::ST_PROGRAM;
      userRunning    = mode == access_mode_pkg::ST_USER;
      bootActive     = mode == access_mode_pkg::ST_BOOT;
      stackPush      = userRunning && monitorInterruptKey && !keyDelay; // see [RULE_07]
      reentryWrite   = mode == access_mode_pkg::ST_PROGRAM; // see [RULE_11]
      reentryIndex   = reentryCount;
      reentryHit     = userRunning && progAddr >= access_mode_pkg::REENTRY_BASE &&
                       progAddr <= access_mode_pkg::LOW_BLOCK_TOP; // see [RULE_10]
      timerIrqOut    = timerIrqReq && userRunning && runKind == access_mode_pkg::RUN_NOBREAK; // see [RULE_12]
      busIsPort      = accessCode == access_mode_pkg::ACCESS_0 || accessCode == access_mode_pkg::ACCESS_3;
      if (andToBusInstruction || orToBusInstruction) begin
         busOpAllowed = accessCode == access_mode_pkg::ACCESS_3 &&
                        runKind == access_mode_pkg::RUN_NOBREAK; // see [RULE_08]
      end else if (latchToBusInstruction) begin
         busOpAllowed = busIsPort; // see [RULE_09]
      end else begin
         busOpAllowed = 1'b1;
      end
      busOpFault     = userRunning && !busOpAllowed;
      // Box drivers release the bus and nibble whenever user hardware may own them.
      busOe          = busCpuDrive && !monitorActive && !bootActive; // see [RULE_05] [RULE_06]
      portTwoLowOe   = !portTwoMapSetting && !bootActive; // see [RULE_06]
      resetLineOut   = 1'b0;
      resetLineOe    = systemResetKey || bootActive; // see [RULE_14]
      cpuResetActive = systemResetKey || !resetLineIn; // see [RULE_14]
   end
endmodule : access_mode_bus_expansion
`default_nettype wire

// ---- src/access_mode_pkg.sv ----
/*
 Constants shared by the access-mode bus expansion logic: access codes,
 address region bounds, run commands and reset timing.
 Assumes a single 20 MHz core clock.
*/
`default_nettype none
package access_mode_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam logic [2:0]  ACCESS_0        = 3'h0;
   localparam logic [2:0]  ACCESS_1        = 3'h1;
   localparam logic [2:0]  ACCESS_2        = 3'h2;
   localparam logic [2:0]  ACCESS_3        = 3'h3;
   localparam logic [2:0]  ACCESS_4        = 3'h4;
   localparam logic [2:0]  ACCESS_5        = 3'h5;
   localparam logic [2:0]  ACCESS_RESET    = 3'h0;
   localparam logic [11:0] LOW_BLOCK_TOP   = 12'h3ff;
   localparam logic [11:0] REENTRY_BASE    = 12'h3f0;
   localparam logic [11:0] INBOX_DATA_TOP  = 12'h0ff;
   localparam logic [11:0] UPPER_BASE      = 12'h800;
   localparam logic [11:0] UPPER_TOP       = 12'hbff;
   localparam int unsigned REENTRY_BYTES   = 16;
   localparam int unsigned MONITOR_BYTES   = 4096;
   // Boot handshake wait before the monitor is declared started.
   localparam int unsigned BOOT_TIME_NS    = 1000;
   localparam int unsigned BOOT_CYCLES     = (BOOT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [1:0]  RUN_NOBREAK     = 2'h0;
   localparam logic [1:0]  RUN_BREAK       = 2'h1;
   localparam logic [1:0]  RUN_STEP        = 2'h2;
   typedef enum logic [3:0] {
      ST_BOOT    = 4'b0001,
      ST_MONITOR = 4'b0010,
      ST_USER    = 4'b0100,
      ST_PROGRAM = 4'b1000
   } mode_e;
endpackage : access_mode_pkg
`default_nettype wire

// ---- src/region_decode.sv ----
/*
 Combinational program and data address decoder for the current access code.
 Assumes the access code is held stable by the controller.
*/
`default_nettype none
module region_decode (
   input  wire logic [2:0]  accessCode,
   input  wire logic        monitorMode,
   input  wire logic [11:0] progAddr,
   input  wire logic [11:0] dataAddr,
   output logic             progLowChip,
   output logic             progLowRam,
   output logic             progMonitor,
   output logic             progExternal,
   output logic             sysCallOk,
   output logic             dataInBox,
   output logic             dataPaged
);
   logic lowBlock;
   logic upper;
   always_comb begin
      lowBlock     = progAddr <= access_mode_pkg::LOW_BLOCK_TOP;
      upper        = !lowBlock;
      // System calls live in monitor memory reachable only in codes 2 and 5.
      sysCallOk    = (accessCode == access_mode_pkg::ACCESS_2) ||
                     (accessCode == access_mode_pkg::ACCESS_5); // see [RULE_01]
      progMonitor  = monitorMode || (upper && sysCallOk); // see [RULE_16]
      progLowChip  = !monitorMode && lowBlock && (accessCode >= access_mode_pkg::ACCESS_3);
      progLowRam   = !monitorMode && lowBlock && (accessCode < access_mode_pkg::ACCESS_3);
      // External program memory only above the low block; the low block is never redirected.
      progExternal = !monitorMode && upper &&
                     ((accessCode == access_mode_pkg::ACCESS_1) ||
                      (accessCode == access_mode_pkg::ACCESS_4)); // see [RULE_02]
      dataInBox    = dataAddr <= access_mode_pkg::INBOX_DATA_TOP; // see [RULE_03]
      dataPaged    = (dataAddr > access_mode_pkg::LOW_BLOCK_TOP) &&
                     (sysCallOk || progExternal ||
                      (accessCode == access_mode_pkg::ACCESS_1) ||
                      (accessCode == access_mode_pkg::ACCESS_4)); // see [RULE_17]
   end
endmodule : region_decode
`default_nettype wire

// ---- verification/access_mode_bus_expansion_properties.sv ----
/* Concurrent checks on the ports of the access-mode controller.
 Assumes it is bound into the top module and shares its clock and reset. */
`default_nettype none
module access_mode_checker (
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       systemResetKey,
   input wire logic       monitorInterruptKey,
   input wire logic       portTwoMapSetting,
   input wire logic       andToBusInstruction,
   input wire logic       orToBusInstruction,
   input wire logic       latchToBusInstruction,
   input wire logic       timerIrqReq,
   input wire logic       runStart,
   input wire logic [1:0] runCommand,
   input wire logic [2:0] accessCode,
   input wire logic       monitorActive,
   input wire logic       userRunning,
   input wire logic       bootActive,
   input wire logic       stackPush,
   input wire logic       timerIrqOut,
   input wire logic       busOpAllowed,
   input wire logic       sysCallOk,
   input wire logic       portTwoLowOe,
   input wire logic       resetLineOut,
   input wire logic       resetLineOe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Remembers whether the last accepted run command was a break or single-step run.
   logic stepOrBreak;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         stepOrBreak <= 1'b0;
      end else if (monitorActive && runStart) begin
         stepOrBreak <= runCommand != 2'h0;
      end
   end
   sys_call_gate_a: assert property (sysCallOk |-> accessCode inside {3'h2, 3'h5})
      else $error("system call reachable outside codes 2 and 5");
   bus_logic_gate_a: assert property ((andToBusInstruction || orToBusInstruction) && busOpAllowed
      |-> accessCode == 3'h3 && !stepOrBreak) else $error("bus and/or allowed outside code 3 no-break run");
   latch_gate_a: assert property (latchToBusInstruction && busOpAllowed
      |-> accessCode inside {3'h0, 3'h3}) else $error("latch to bus allowed outside codes 0 and 3");
   key_push_a: assert property ($rose(monitorInterruptKey) && userRunning && !systemResetKey
      |-> stackPush ##1 monitorActive) else $error("monitor key did not push and enter monitor");
   timer_pass_a: assert property (timerIrqOut |-> timerIrqReq && userRunning && !stepOrBreak)
      else $error("timer interrupt passed outside a no-break user run");
   reset_key_a: assert property (systemResetKey |=> accessCode == 3'h0 && bootActive)
      else $error("reset key did not clear access code and boot");
   reset_drive_a: assert property (systemResetKey |-> resetLineOe && !resetLineOut)
      else $error("reset key does not pull the reset line low");
   port_owner_a: assert property (portTwoMapSetting |-> !portTwoLowOe)
      else $error("box drives nibble owned by user");
   cover property (stackPush);
   cover property (systemResetKey);
   cover property (busOpAllowed);
endmodule : access_mode_checker
bind access_mode_bus_expansion access_mode_checker i_access_mode_checker (.core_clk, .nrst, .systemResetKey,
   .monitorInterruptKey, .portTwoMapSetting, .andToBusInstruction, .orToBusInstruction, .latchToBusInstruction,
   .timerIrqReq, .runStart, .runCommand, .accessCode, .monitorActive, .userRunning, .bootActive, .stackPush,
   .timerIrqOut,
   .busOpAllowed, .sysCallOk, .portTwoLowOe, .resetLineOut, .resetLineOe);
`default_nettype wire

// ---- verification/tb.sv ----
/* Self-checking bench for the access-mode controller.
 Assumes the checker binds itself and the prototype model resolves connector lines. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, nrst, systemResetKey, monitorInterruptKey, setAccess, portTwoMapSetting, runStart;
   logic programPromCmd, programDone, andToBusInstruction, orToBusInstruction, latchToBusInstruction;
   logic timerIrqReq, busCpuDrive, extReset, resetLineIn, portTwoLowOe, resetLineOut, resetLineOe;
   logic monitorActive, userRunning, bootActive, stackPush, timerIrqOut, busOpAllowed, sysCallOk, cpuResetActive;
   logic busOpFault, dataPageValid, reentryWrite, progMonitor, progExternal, reentryHit, dataInBox, busOe;
   logic [2:0]  accessIn, accessCode;
   logic [1:0]  runCommand;
   logic [11:0] progAddr, dataAddr;
   logic [3:0]  portTwoLowIn, portTwoLowCpu, portTwoLowOut, dataPage, userPage, reentryIndex;
   logic [7:0]  busCpuOut;
   int          err_total, tests_run, cycles;
   access_mode_bus_expansion i_access_mode_bus_expansion (.core_clk, .nrst, .systemResetKey,
      .monitorInterruptKey, .setAccess, .accessIn, .portTwoMapSetting, .runStart, .runCommand,
      .programPromCmd, .programDone, .progAddr, .dataAddr, .andToBusInstruction, .orToBusInstruction,
      .latchToBusInstruction, .timerIrqReq, .portTwoLowIn, .portTwoLowCpu, .busCpuOut, .busCpuDrive,
      .resetLineIn, .accessCode, .monitorActive, .userRunning, .bootActive, .stackPush, .reentryWrite,
      .reentryIndex, .timerIrqOut, .busOpAllowed, .busOpFault, .dataPage, .dataPageValid,
      .progLowChip(), .progLowRam(), .progMonitor, .progExternal, .reentryHit, .sysCallOk,
      .dataInBox, .busOut(), .busOe, .portTwoLowOut, .portTwoLowOe, .resetLineOut, .resetLineOe,
      .cpuResetActive);
   user_proto_model i_user_proto_model (.portTwoLowOe, .portTwoLowOut, .resetLineOe, .resetLineOut,
      .extReset, .userPage, .portTwoLowIn, .resetLineIn);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic set_code(input logic [2:0] c);
      @(posedge core_clk) setAccess <= 1'b1;
      accessIn <= c;
      @(posedge core_clk) setAccess <= 1'b0;
      #1;
   endtask : set_code
   task automatic run(input logic [1:0] cmd);
      @(posedge core_clk) runStart <= 1'b1;
      runCommand <= cmd;
      @(posedge core_clk) runStart <= 1'b0;
      #1;
   endtask : run
   task automatic key_break;
      @(posedge core_clk) monitorInterruptKey <= 1'b1;
      #1 check(stackPush, 1'b1);
      @(posedge core_clk) monitorInterruptKey <= 1'b0;
      #1 check(monitorActive, 1'b1);
   endtask : key_break
   task automatic wait_monitor;
      for (int i = 0; i < 60 && monitorActive !== 1'b1; i++) @(posedge core_clk);
      #1 check(monitorActive, 1'b1);
   endtask : wait_monitor
   task automatic test_codes;
      for (int c = 0; c < 6; c++) begin
         set_code(3'(c));
         check(accessCode, 12'(c));
         check(sysCallOk, 12'(c == 2 || c == 5));
      end
      set_code(3'h6);
      check(accessCode, 3'h5);
   endtask : test_codes
   task automatic test_bus_logic;
      set_code(access_mode_pkg::ACCESS_3);
      run(access_mode_pkg::RUN_NOBREAK);
      check(userRunning, 1'b1);
      check(progMonitor, 1'b0);
      @(posedge core_clk) andToBusInstruction <= 1'b1;
      busCpuDrive <= 1'b1;
      #1 check(busOpAllowed, 1'b1);
      check(busOe, 1'b1);
      key_break();
      check(busOe, 1'b0);
      run(access_mode_pkg::RUN_BREAK);
      check(busOpAllowed, 1'b0);
      check(busOpFault, 1'b1);
      key_break();
      @(posedge core_clk) andToBusInstruction <= 1'b0;
      busCpuDrive <= 1'b0;
   endtask : test_bus_logic
   task automatic test_timer_step;
      set_code(access_mode_pkg::ACCESS_0);
      run(access_mode_pkg::RUN_STEP);
      @(posedge core_clk) timerIrqReq <= 1'b1;
      latchToBusInstruction <= 1'b1;
      #1 check(timerIrqOut, 1'b0);
      check(busOpAllowed, 1'b1);
      check(reentryHit, 1'b0);
      check(progExternal, 1'b0);
      key_break();
      run(access_mode_pkg::RUN_NOBREAK);
      check(timerIrqOut, 1'b1);
      key_break();
      @(posedge core_clk) timerIrqReq <= 1'b0;
      latchToBusInstruction <= 1'b0;
   endtask : test_timer_step
   task automatic test_prom;
      @(posedge core_clk) programPromCmd <= 1'b1;
      @(posedge core_clk) programPromCmd <= 1'b0;
      programDone <= 1'b1;
      #1 check(reentryWrite, 1'b1);
      check(reentryIndex, 12'h000);
      repeat (access_mode_pkg::REENTRY_BYTES) @(posedge core_clk);
      programDone <= 1'b0;
      #1 check(reentryWrite, 1'b0);
      check(reentryIndex, 12'(access_mode_pkg::REENTRY_BYTES - 1));
   endtask : test_prom
   task automatic test_paging;
      @(posedge core_clk) portTwoMapSetting <= 1'b1;
      userPage <= 4'ha;
      dataAddr <= 12'h400;
      set_code(access_mode_pkg::ACCESS_1);
      @(posedge core_clk) latchToBusInstruction <= 1'b1;
      #1 check(dataPage, 4'ha);
      check(portTwoLowOe, 1'b0);
      check(dataPageValid, 1'b1);
      check(dataInBox, 1'b0);
      check(busOpAllowed, 1'b0);
      @(posedge core_clk) dataAddr <= 12'h0ff;
      latchToBusInstruction <= 1'b0;
      #1 check(dataInBox, 1'b1);
      run(access_mode_pkg::RUN_NOBREAK);
      check(progExternal, 1'b1);
      key_break();
   endtask : test_paging
   task automatic test_reset_key;
      @(posedge core_clk) systemResetKey <= 1'b1;
      #1 check(cpuResetActive, 1'b1);
      @(posedge core_clk) systemResetKey <= 1'b0;
      #1 check(accessCode, 3'h0);
      check(bootActive, 1'b1);
      wait_monitor();
      @(posedge core_clk) extReset <= 1'b1;
      #1 check(cpuResetActive, 1'b1);
      @(posedge core_clk) extReset <= 1'b0;
      #1 check(cpuResetActive, 1'b0);
   endtask : test_reset_key
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      {nrst, systemResetKey, monitorInterruptKey, setAccess, portTwoMapSetting, runStart} = '0;
      {programPromCmd, programDone, andToBusInstruction, orToBusInstruction, latchToBusInstruction} = '0;
      {timerIrqReq, busCpuDrive, extReset, accessIn, runCommand, portTwoLowCpu, busCpuOut} = '0;
      progAddr = 12'h800;
      dataAddr = 12'h000;
      userPage = 4'h5;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      wait_monitor();
      test_codes();
      test_bus_logic();
      test_timer_step();
      test_prom();
      test_paging();
      test_reset_key();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire

// ---- verification/user_proto_model.sv ----
/* Model of the user prototype on the expansion connector.
 Assumes it owns the port-2 low nibble whenever the box lets go of it. */
`default_nettype none
module user_proto_model (
   input  wire logic       portTwoLowOe,
   input  wire logic [3:0] portTwoLowOut,
   input  wire logic       resetLineOe,
   input  wire logic       resetLineOut,
   input  wire logic       extReset,
   input  wire logic [3:0] userPage,
   output logic [3:0]      portTwoLowIn,
   output logic            resetLineIn
);
   assign portTwoLowIn = portTwoLowOe ? portTwoLowOut : userPage;
   // The pull-up holds the line high unless someone pulls it low.
   assign resetLineIn = ((resetLineOe && !resetLineOut) || extReset) ? 1'b0 : 1'b1;
endmodule : user_proto_model
`default_nettype wire
